// ===== dmr_pkg.sv
package dmr_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] DMR_IDX_SETUP = 8'h23;
    localparam logic [7:0] DMR_IDX_FAULT = 8'h24;
    localparam logic [7:0] DMR_IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] DMR_IDX_IRQ_MASK = 8'h31;
    localparam logic [7:0] DMR_IDX_CONTROL = 8'h32;
    localparam int DMR_ADDR_W = 10;

    localparam logic [7:0] DMR_SETUP_RESET = 8'h00;
    localparam logic [7:0] DMR_FAULT_RESET = 8'h00;
    localparam logic [7:0] DMR_IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] DMR_IRQ_MASK_RESET = 8'h00;

    // setup fields
    localparam int DMR_FUNC_MSB = 7;
    localparam int DMR_FUNC_LSB = 6;
    localparam int DMR_BUF_BIT = 5;
    localparam int DMR_BIAS_BIT = 4;
    localparam int DMR_CH_MSB = 3;
    localparam int DMR_CH_LSB = 0;

    // fault fields
    localparam int DMR_MAP_ERR_BIT = 7;
    localparam int DMR_REF_FAULT_BIT = 3;
    localparam int DMR_NEG_CH0_BIT = 2;
    localparam int DMR_OVER_TEMP_BIT = 1;
    localparam int DMR_TEMP_WARN_BIT = 0;

    // control register: bit 0 written as one issues the reset command
    localparam int DMR_CTRL_RESET_BIT = 0;

    localparam int DMR_NUM_CHANNELS = 6;
    localparam int DMR_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        DMR_FUNC_OFF = 2'h0,
        DMR_FUNC_VOLTAGE = 2'h1,
        DMR_FUNC_CURRENT = 2'h2,
        DMR_FUNC_TEMP = 2'h3
    } dmr_func_t;

    typedef struct packed {
        dmr_func_t diag_function_sel;
        logic selector_buffer_en;
        logic diode_bias_external;
        logic [3:0] diag_channel_sel;
    } dmr_setup_t;

    typedef struct packed {
        logic map_check_fail;
        logic ref_res_fault_det;
        logic neg_voltage_det;
        logic die_at_145c;
        logic die_at_125c;
        logic die_below_120c;
    } dmr_sense_t;

    typedef struct packed {
        logic map_integrity_err;
        logic [2:0] unused;
        logic ref_resistor_fault;
        logic neg_voltage_ch_zero;
        logic over_temp;
        logic temp_warning;
    } dmr_fault_t;

    typedef struct packed {
        logic mon_voltage_en;
        logic mon_current_en;
        logic mon_temp_en;
        logic selector_buffer_en;
        logic selector_bypass;
        logic diode_bias_external;
        logic internal_bias_en;
        logic use_internal_ref_res;
        logic [DMR_NUM_CHANNELS-1:0] channel_onehot;
    } dmr_analog_ctl_t;

endpackage

// ===== dmr_sync.sv
`timescale 1ns/1ns
module dmr_sync #(
    parameter int WIDTH = 6
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;
endmodule

// ===== dmr_regs.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module dmr_regs (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [dmr_pkg::DMR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire dmr_pkg::dmr_sense_t sense_in,
    output dmr_pkg::dmr_analog_ctl_t analog_ctl,
    output dmr_pkg::dmr_setup_t setup_out,
    output dmr_pkg::dmr_fault_t fault_out,
    output logic irq
);
    localparam int NSENSE = $bits(dmr_pkg::dmr_sense_t);

    dmr_pkg::dmr_sense_t sense_sync;
    logic [NSENSE-1:0] sense_sync_bits;

    dmr_pkg::dmr_setup_t setup_reg;
    dmr_pkg::dmr_setup_t setup_next;
    dmr_pkg::dmr_fault_t fault_reg;
    dmr_pkg::dmr_fault_t fault_next;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_status_next;
    logic [7:0] irq_mask_reg;
    logic [7:0] irq_mask_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;

    // pins from the analog side are asynchronous to mclk
    dmr_sync #(
        .WIDTH(NSENSE)
    ) u_sense_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in(sense_in),
        .sync_out(sense_sync_bits)
    );
    assign sense_sync = dmr_pkg::dmr_sense_t'(sense_sync_bits);

    // bus decode; one wait state so read data come from a flop
    wire req = avs_read | avs_write;
    wire [7:0] word_idx = avs_address[9:2];
    wire hit_setup = word_idx == dmr_pkg::DMR_IDX_SETUP;
    wire hit_fault = word_idx == dmr_pkg::DMR_IDX_FAULT;
    wire hit_irq_status = word_idx == dmr_pkg::DMR_IDX_IRQ_STATUS;
    wire hit_irq_mask = word_idx == dmr_pkg::DMR_IDX_IRQ_MASK;
    wire hit_control = word_idx == dmr_pkg::DMR_IDX_CONTROL;
    wire wr_commit = avs_write & ack_reg & avs_byteenable[0];
    wire [7:0] wdata = avs_writedata[7:0];
    wire wr_setup = wr_commit & hit_setup;
    wire wr_irq_status = wr_commit & hit_irq_status;
    wire wr_irq_mask = wr_commit & hit_irq_mask;
    wire reset_cmd = wr_commit & hit_control & wdata[dmr_pkg::DMR_CTRL_RESET_BIT];

    assign ack_next = req & ~ack_reg;
    assign avs_waitrequest = req & ~ack_reg;

    // writes to the fault register are decoded but have no effect
    wire [7:0] rd_mux =
        hit_setup ? setup_reg :
        hit_fault ? fault_reg :
        hit_irq_status ? irq_status_reg :
        hit_irq_mask ? irq_mask_reg :
        8'h00;
    assign readdata_next = (avs_read & ~ack_reg) ? {24'h000000, rd_mux} : readdata_reg;
    assign avs_readdata = readdata_reg;

    // setup register; the reset command returns it to zero as well
    always_comb begin
        setup_next = setup_reg;
        if (reset_cmd) begin
            setup_next = dmr_pkg::DMR_SETUP_RESET;
        end else if (wr_setup) begin
            setup_next = dmr_pkg::dmr_setup_t'(wdata);
        end
    end

    // condition terms for each flag
    wire ch0_monitored = (setup_reg.diag_function_sel == dmr_pkg::DMR_FUNC_VOLTAGE ||
        setup_reg.diag_function_sel == dmr_pkg::DMR_FUNC_CURRENT) &&
        setup_reg.diag_channel_sel == 4'h0;
    wire set_map_err = sense_sync.map_check_fail;
    wire set_ref_fault = sense_sync.ref_res_fault_det;
    wire set_neg_ch0 = sense_sync.neg_voltage_det & ch0_monitored;
    wire set_over_temp = sense_sync.die_at_145c;
    wire set_warn = sense_sync.die_at_125c;
    wire clr_warn = sense_sync.die_below_120c;

    // latched faults clear only on the reset command; a live fault sets again at once
    always_comb begin
        fault_next = fault_reg;
        if (reset_cmd) begin
            fault_next = dmr_pkg::DMR_FAULT_RESET;
        end
        if (set_map_err) begin
            fault_next.map_integrity_err = 1'b1;
        end
        if (set_ref_fault) begin
            fault_next.ref_resistor_fault = 1'b1;
        end
        if (set_neg_ch0) begin
            fault_next.neg_voltage_ch_zero = 1'b1;
        end
        if (set_over_temp) begin
            fault_next.over_temp = 1'b1;
        end
        // hysteresis: between 120C and 125C the flag keeps its value
        if (set_warn) begin
            fault_next.temp_warning = 1'b1;
        end else if (clr_warn) begin
            fault_next.temp_warning = 1'b0;
        end
        fault_next.unused = 3'h0;
    end

    // interrupt events are rising edges of the fault flags
    wire [7:0] fault_rise = fault_next & ~fault_reg;
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_irq_status) begin
            irq_status_next = irq_status_reg & ~wdata;
        end
        if (reset_cmd) begin
            irq_status_next = dmr_pkg::DMR_IRQ_STATUS_RESET;
        end
        // set wins over a clear in the same cycle
        irq_status_next = irq_status_next | fault_rise;
    end
    assign irq_mask_next = wr_irq_mask ? wdata : irq_mask_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            setup_reg <= dmr_pkg::DMR_SETUP_RESET;
            fault_reg <= dmr_pkg::DMR_FAULT_RESET;
        end else begin
            setup_reg <= setup_next;
            fault_reg <= fault_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_reg <= dmr_pkg::DMR_IRQ_STATUS_RESET;
            irq_mask_reg <= dmr_pkg::DMR_IRQ_MASK_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            readdata_reg <= readdata_next;
        end
    end

    // analog controls decoded from the setup register, the resistor choice from the fault register
    assign analog_ctl.mon_voltage_en =
        setup_reg.diag_function_sel == dmr_pkg::DMR_FUNC_VOLTAGE;
    assign analog_ctl.mon_current_en =
        setup_reg.diag_function_sel == dmr_pkg::DMR_FUNC_CURRENT;
    assign analog_ctl.mon_temp_en =
        setup_reg.diag_function_sel == dmr_pkg::DMR_FUNC_TEMP;
    assign analog_ctl.selector_buffer_en = setup_reg.selector_buffer_en;
    assign analog_ctl.selector_bypass = ~setup_reg.selector_buffer_en;
    assign analog_ctl.diode_bias_external = setup_reg.diode_bias_external;
    assign analog_ctl.internal_bias_en = ~setup_reg.diode_bias_external;
    // latched fault keeps the internal resistor until the reset command
    assign analog_ctl.use_internal_ref_res = fault_reg.ref_resistor_fault;

    // codes above five select nothing; channel only matters in voltage or current mode
    wire ch_mode = analog_ctl.mon_voltage_en | analog_ctl.mon_current_en;
    genvar c;
    generate
        for (c = 0; c < dmr_pkg::DMR_NUM_CHANNELS; c++) begin : g_ch
            assign analog_ctl.channel_onehot[c] = ch_mode &&
                setup_reg.diag_channel_sel == 4'(c);
        end
    endgenerate

    assign setup_out = setup_reg;
    assign fault_out = fault_reg;
endmodule

// ===== dmr_regs_sva.sv
`timescale 1ns/1ns
module dmr_regs_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [dmr_pkg::DMR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire dmr_pkg::dmr_sense_t sense_in,
    input wire dmr_pkg::dmr_analog_ctl_t analog_ctl,
    input wire dmr_pkg::dmr_setup_t setup_out,
    input wire dmr_pkg::dmr_fault_t fault_out,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic [1:0] fn = setup_out.diag_function_sel;
    wire logic [3:0] ch = setup_out.diag_channel_sel;
    wire logic mon_vi = fn == 2'h1 || fn == 2'h2;
    wire logic [5:0] oh_exp = (mon_vi && ch < 4'h6) ? 6'h01 << ch : 6'h00;
    // only a committed write may clear a latched flag
    wire logic rst_cmd = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_writedata[0]
        && avs_address[9:2] == dmr_pkg::DMR_IDX_CONTROL;
    func_decode_a: assert property (
        {analog_ctl.mon_voltage_en, analog_ctl.mon_current_en, analog_ctl.mon_temp_en}
        == {fn == 2'h1, fn == 2'h2, fn == 2'h3}) else $error("function decode wrong");
    buffer_sel_a: assert property (
        analog_ctl.selector_buffer_en == setup_out.selector_buffer_en
        && analog_ctl.selector_bypass != setup_out.selector_buffer_en) else $error("buffer wrong");
    bias_src_a: assert property (
        analog_ctl.diode_bias_external == setup_out.diode_bias_external
        && analog_ctl.internal_bias_en != setup_out.diode_bias_external) else $error("bias wrong");
    chan_pick_a: assert property (
        analog_ctl.channel_onehot == oh_exp) else $error("channel select wrong");
    map_err_a: assert property (
        sense_in.map_check_fail [*3] |=> fault_out.map_integrity_err) else $error("map flag late");
    ref_switch_a: assert property (
        fault_out.ref_resistor_fault |-> analog_ctl.use_internal_ref_res) else $error("ref res");
    neg_cause_a: assert property (
        $rose(fault_out.neg_voltage_ch_zero) |-> $past(mon_vi && ch == 4'h0))
        else $error("negative flag without channel zero");
    over_set_a: assert property (
        sense_in.die_at_145c [*3] |=> fault_out.over_temp) else $error("overtemp flag late");
    over_hold_a: assert property (
        $fell(fault_out.over_temp) |-> $past(rst_cmd)) else $error("overtemp cleared early");
    warn_set_a: assert property (
        sense_in.die_at_125c [*3] |=> fault_out.temp_warning) else $error("warning flag late");
    unused_zero_a: assert property (
        fault_out[6:4] == 3'h0 && avs_readdata[31:8] == 24'h0) else $error("unused bits set");
endmodule
bind dmr_regs dmr_regs_chk i_dmr_regs_chk (.mclk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .sense_in, .analog_ctl, .setup_out, .fault_out, .irq);

// ===== test_dmr_regs.sv
`timescale 1ns/1ns
module test_dmr_regs;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    dmr_pkg::dmr_sense_t sense_in = '0;
    dmr_pkg::dmr_analog_ctl_t analog_ctl;
    dmr_pkg::dmr_setup_t setup_out;
    dmr_pkg::dmr_fault_t fault_out;
    logic irq;
    logic [31:0] rdata;
    logic [31:0] e;
    logic [7:0] s;
    int mismatches = 0;
    int n_checks = 0;
    always #2 mclk = ~mclk;
    dmr_regs i_dmr_regs (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .sense_in, .analog_ctl, .setup_out,
        .fault_out, .irq);
    task automatic summarize();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // request held until the edge that sees waitrequest low; data taken at that edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n < 20) begin
            @(posedge mclk);
        end else begin
            mismatches++;
            summarize();
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk("ctl", {18'h0, analog_ctl}, 32'h0280);
        bus(1'b0, 10'h08c, 8'h00);
        chk("setup", rdata, 32'h0);
        for (int f = 0; f < 4; f++) begin
            for (int c = 0; c < 7; c++) begin
                s = {f[1:0], f[0], f[1], c[3:0]};
                bus(1'b1, 10'h08c, s);
                bus(1'b0, 10'h08c, 8'h00);
                chk("setup", rdata, {24'h0, s});
                chk("setup_out", {24'h0, setup_out}, {24'h0, s});
                e = {18'h0, f == 1, f == 2, f == 3, f[0], !f[0], f[1], !f[1], 7'h00};
                e[5:0] = (f == 1 || f == 2) && c < 6 ? 6'h01 << c : 6'h00;
                chk("ctl", {18'h0, analog_ctl}, e);
            end
        end
        bus(1'b1, 10'h090, 8'hff);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h0);
        chk("fault_out", {24'h0, fault_out}, 32'h0);
        bus(1'b0, 10'h3fc, 8'h00);
        chk("unmapped", rdata, 32'h0);
        // negative voltage while channel one is watched must not flag
        bus(1'b1, 10'h08c, 8'h81);
        sense_in <= 6'b001000;
        repeat (6) @(posedge mclk);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h0);
        bus(1'b1, 10'h0c4, 8'h8f);
        bus(1'b1, 10'h08c, 8'h40);
        sense_in <= 6'b111110;
        repeat (6) @(posedge mclk);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h8f);
        chk("ref res", {31'h0, analog_ctl.use_internal_ref_res}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("fault_out", {24'h0, fault_out}, 32'h8f);
        // between the two thresholds the warning must hold
        sense_in <= 6'b111100;
        repeat (6) @(posedge mclk);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h8f);
        sense_in <= 6'b000001;
        repeat (6) @(posedge mclk);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h8e);
        bus(1'b0, 10'h0c0, 8'h00);
        chk("irq status", rdata, 32'h8f);
        bus(1'b0, 10'h0c4, 8'h00);
        chk("irq mask", rdata, 32'h8f);
        bus(1'b1, 10'h0c4, 8'h00);
        chk("irq", {31'h0, irq}, 32'h0);
        bus(1'b1, 10'h0c4, 8'h8f);
        chk("irq", {31'h0, irq}, 32'h1);
        bus(1'b1, 10'h0c0, 8'hff);
        chk("irq", {31'h0, irq}, 32'h0);
        bus(1'b1, 10'h0c8, 8'h01);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h0);
        bus(1'b0, 10'h08c, 8'h00);
        chk("setup", rdata, 32'h0);
        bus(1'b0, 10'h0c8, 8'h00);
        chk("control", rdata, 32'h0);
        // byte lane zero off: the write must be dropped
        avs_byteenable <= 4'he;
        bus(1'b1, 10'h08c, 8'hc5);
        avs_byteenable <= 4'hf;
        bus(1'b0, 10'h08c, 8'h00);
        chk("setup", rdata, 32'h0);
        // a live fault wins over the reset command
        sense_in <= 6'b000100;
        repeat (6) @(posedge mclk);
        bus(1'b1, 10'h0c8, 8'h01);
        bus(1'b0, 10'h090, 8'h00);
        chk("fault", rdata, 32'h02);
        sense_in <= 6'b000000;
        repeat (6) @(posedge mclk);
        bus(1'b1, 10'h0c8, 8'h01);
        chk("fault_out", {24'h0, fault_out}, 32'h0);
        summarize();
    end
endmodule
